// ===== logic/mpks_device.sv
// Module end: power key sequencing, power-down state and airplane mode.
`timescale 1ns/1ps
module mpks_device
    import mpks_pkg::*;
#(
    parameter int              TICK    = TICK_CYCLES,
    parameter logic [MS_W-1:0] BOOT_MS = BOOT_MS_DFLT,
    parameter logic [MS_W-1:0] HALT_MS = HALT_MS_DFLT
) (
    input  wire logic   clk,
    input  wire logic   reset,
    mpks_link_if.dev    link,
    input  wire logic   shutdown_command,
    input  wire logic   functionality_command,
    input  wire logic   func_airplane,
    output logic        core_power,
    output logic        software_active,
    output logic        serial_ready,
    output logic        radio_enable,
    output logic        airplane,
    output logic        running
);

    localparam int TW = (TICK > 1) ? $clog2(TICK) : 1;

    logic [TW-1:0]   div_ff;
    logic [TW-1:0]   nxt_div;
    logic            tick;

    mpks_dev_state_e state_ff;
    mpks_dev_state_e nxt_state;
    logic [MS_W-1:0] key_ms_ff;
    logic [MS_W-1:0] nxt_key_ms;
    logic [MS_W-1:0] timer_ff;
    logic [MS_W-1:0] nxt_timer;
    logic            armed_ff;
    logic            nxt_armed;
    logic            by_cmd_ff;
    logic            nxt_by_cmd;
    logic            air_cmd_ff;
    logic            nxt_air_cmd;

    logic            status_low_ff;
    logic            nxt_status_low;
    logic            core_ff;
    logic            nxt_core;
    logic            radio_ff;
    logic            nxt_radio;
    logic            air_ff;
    logic            nxt_air;
    logic            run_ff;
    logic            nxt_run;

    logic            key_low;
    logic            supply_ok;
    logic            live;

    assign key_low   = ~link.power_key_n;
    assign supply_ok = link.baseband_supply & link.radio_supply;

    // Free-running millisecond time base.
    assign tick = (div_ff == TW'(TICK - 1));

    always_comb begin
        nxt_div = tick ? '0 : TW'(div_ff + 1'b1);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    always_comb begin
        nxt_state   = state_ff;
        nxt_timer   = timer_ff;
        nxt_armed   = armed_ff;
        nxt_by_cmd  = by_cmd_ff;
        nxt_air_cmd = air_cmd_ff;
        nxt_key_ms  = key_ms_ff;

        // Any high sample restarts the low interval; it only grows while held low.
        if (!key_low) begin
            nxt_key_ms = '0;
        end else if (tick && (key_ms_ff != MS_MAX)) begin
            nxt_key_ms = MS_W'(key_ms_ff + 1'b1);
        end

        if (tick && (timer_ff != MS_MAX)) begin
            nxt_timer = MS_W'(timer_ff + 1'b1);
        end

        case (state_ff)
            DEV_OFF: begin
                nxt_air_cmd = 1'b0;
                if (key_low && (key_ms_ff >= KEY_ON_MS)) begin
                    nxt_state = DEV_BOOT;
                    nxt_timer = '0;
                end
            end
            DEV_BOOT: begin
                if (timer_ff >= BOOT_MS) begin
                    nxt_state = DEV_RUN;
                    nxt_armed = 1'b0;
                end
            end
            DEV_RUN: begin
                // The power-on press is usually still held here, so a power-off
                // press only counts after the key has been seen high once.
                if (!key_low) begin
                    nxt_armed = 1'b1;
                end
                if (functionality_command) begin
                    nxt_air_cmd = func_airplane;
                end
                if (shutdown_command) begin
                    nxt_state  = DEV_HALT;
                    nxt_by_cmd = 1'b1;
                    nxt_timer  = '0;
                end else if (armed_ff && key_low && (key_ms_ff >= KEY_OFF_MS)) begin
                    nxt_state = DEV_KEY_HELD;
                end
            end
            DEV_KEY_HELD: begin
                if (functionality_command) begin
                    nxt_air_cmd = func_airplane;
                end
                if (!key_low) begin
                    nxt_state  = DEV_HALT;
                    nxt_by_cmd = 1'b0;
                    nxt_timer  = '0;
                end
            end
            DEV_HALT: begin
                if (timer_ff >= HALT_MS) begin
                    nxt_timer = '0;
                    if (by_cmd_ff && key_low) begin
                        nxt_state = DEV_BOOT;
                    end else begin
                        nxt_state = DEV_OFF;
                    end
                    nxt_by_cmd = 1'b0;
                end
            end
            default: begin
                nxt_state = DEV_OFF;
            end
        endcase

        // Without both external rails nothing inside can run.
        if (!supply_ok) begin
            nxt_state   = DEV_OFF;
            nxt_by_cmd  = 1'b0;
            nxt_air_cmd = 1'b0;
            nxt_armed   = 1'b0;
        end
    end

    // Output decode is taken from the next state so the pins change with the state.
    always_comb begin
        live = (nxt_state != DEV_OFF);
        nxt_core       = live;
        nxt_run        = (nxt_state == DEV_RUN) || (nxt_state == DEV_KEY_HELD);
        nxt_status_low = nxt_run || (nxt_state == DEV_HALT);
        nxt_air        = nxt_run && (nxt_air_cmd || !link.radio_disable_n);
        nxt_radio      = nxt_run && !nxt_air;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff      <= DEV_OFF;
            key_ms_ff     <= '0;
            timer_ff      <= '0;
            armed_ff      <= 1'b0;
            by_cmd_ff     <= 1'b0;
            air_cmd_ff    <= 1'b0;
            status_low_ff <= 1'b0;
            core_ff       <= 1'b0;
            radio_ff      <= 1'b0;
            air_ff        <= 1'b0;
            run_ff        <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            key_ms_ff     <= nxt_key_ms;
            timer_ff      <= nxt_timer;
            armed_ff      <= nxt_armed;
            by_cmd_ff     <= nxt_by_cmd;
            air_cmd_ff    <= nxt_air_cmd;
            status_low_ff <= nxt_status_low;
            core_ff       <= nxt_core;
            radio_ff      <= nxt_radio;
            air_ff        <= nxt_air;
            run_ff        <= nxt_run;
        end
    end

    // Status is open-drain: pull low while up, release to the pull-up otherwise.
    assign link.dev_status_out  = 1'b0;
    assign link.dev_status_oe_n = ~status_low_ff;

    assign core_power      = core_ff;
    assign software_active = core_ff;
    assign serial_ready    = run_ff;
    assign radio_enable    = radio_ff;
    assign airplane        = air_ff;
    assign running         = run_ff;

endmodule

// ===== logic/mpks_host.sv
// Host controller end: supply control and power key presses.
`timescale 1ns/1ps
module mpks_host
    import mpks_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    input  wire logic   clk,
    input  wire logic   reset,
    mpks_link_if.host   link,
    input  wire logic   power_on_req,
    input  wire logic   power_off_req,
    input  wire logic   radio_off,
    output logic        module_on,
    output logic        strap_pullup_en,
    output logic        busy
);

    localparam int TW = (TICK > 1) ? $clog2(TICK) : 1;

    logic [TW-1:0]    div_ff;
    logic [TW-1:0]    nxt_div;
    logic             tick;
    mpks_host_state_e state_ff;
    mpks_host_state_e nxt_state;
    logic [MS_W-1:0]  timer_ff;
    logic [MS_W-1:0]  nxt_timer;
    logic             supply_ff;
    logic             nxt_supply;
    logic             press_ff;
    logic             nxt_press;
    logic             rdis_n_ff;
    logic             nxt_rdis_n;
    logic             status_low;

    assign status_low = ~link.status_n;
    assign tick       = (div_ff == TW'(TICK - 1));

    always_comb begin
        nxt_div = tick ? '0 : TW'(div_ff + 1'b1);
    end

    // Timers compare with "greater than" because the first tick may arrive at
    // once; one extra tick guarantees the full minimum time.
    always_comb begin
        nxt_state  = state_ff;
        nxt_timer  = timer_ff;
        nxt_rdis_n = ~radio_off;
        if (tick && (timer_ff != MS_MAX)) begin
            nxt_timer = MS_W'(timer_ff + 1'b1);
        end
        case (state_ff)
            HST_OFF: begin
                if (power_on_req) begin
                    nxt_state = HST_SETTLE;
                    nxt_timer = '0;
                end
            end
            HST_SETTLE: begin
                if (timer_ff > SUPPLY_SET_MS) begin
                    nxt_state = HST_PRESS_ON;
                    nxt_timer = '0;
                end
            end
            HST_PRESS_ON: begin
                if ((timer_ff > KEY_ON_MS) && status_low) begin
                    nxt_state = HST_ON;
                end
            end
            HST_ON: begin
                if (!status_low) begin
                    nxt_state = HST_OFF;
                end else if (power_off_req) begin
                    nxt_state = HST_PRESS_OFF;
                    nxt_timer = '0;
                end
            end
            HST_PRESS_OFF: begin
                if (timer_ff > KEY_OFF_MS) begin
                    nxt_state = HST_WAIT_DOWN;
                end
            end
            HST_WAIT_DOWN: begin
                if (!status_low) begin
                    nxt_state = HST_OFF;
                end
            end
            default: begin
                nxt_state = HST_OFF;
            end
        endcase
        nxt_supply = (nxt_state != HST_OFF);
        nxt_press  = (nxt_state == HST_PRESS_ON) || (nxt_state == HST_PRESS_OFF);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div_ff    <= '0;
            state_ff  <= HST_OFF;
            timer_ff  <= '0;
            supply_ff <= 1'b0;
            press_ff  <= 1'b0;
            rdis_n_ff <= 1'b1;
        end else begin
            div_ff    <= nxt_div;
            state_ff  <= nxt_state;
            timer_ff  <= nxt_timer;
            supply_ff <= nxt_supply;
            press_ff  <= nxt_press;
            rdis_n_ff <= nxt_rdis_n;
        end
    end

    assign link.host_key_out    = 1'b0;
    assign link.host_key_oe_n   = ~press_ff;
    assign link.baseband_supply = supply_ff;
    assign link.radio_supply    = supply_ff;
    assign link.radio_disable_n = rdis_n_ff;

    assign module_on       = (state_ff == HST_ON);
    assign strap_pullup_en = (state_ff == HST_ON);
    assign busy            = (state_ff != HST_ON) && (state_ff != HST_OFF);

endmodule

// ===== logic/mpks_link_if.sv
// Pin-level link between the host controller and the module.
`timescale 1ns/1ps
interface mpks_link_if;
    logic host_key_out;
    logic host_key_oe_n;
    logic dev_status_out;
    logic dev_status_oe_n;
    logic radio_disable_n;
    logic baseband_supply;
    logic radio_supply;
    logic power_key_n;
    logic status_n;

    // Both open-drain lines have external pull-ups, so an undriven line reads high.
    assign power_key_n = host_key_oe_n ? 1'b1 : host_key_out;
    assign status_n    = dev_status_oe_n ? 1'b1 : dev_status_out;

    modport dev (
        input  power_key_n,
        input  radio_disable_n,
        input  baseband_supply,
        input  radio_supply,
        output dev_status_out,
        output dev_status_oe_n
    );

    modport host (
        output host_key_out,
        output host_key_oe_n,
        output radio_disable_n,
        output baseband_supply,
        output radio_supply,
        input  status_n
    );
endinterface

// ===== logic/mpks_pkg.sv
// Shared constants and state encodings for the power key sequencer ends.
package mpks_pkg;

    // System clock and the millisecond time base derived from it.
    localparam int CLK_HZ      = 20_000_000;
    localparam int MS_PER_S    = 1000;
    localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;

    // All sequence timers count whole milliseconds in this width.
    localparam int MS_W = 10;

    // Key and supply timing, in milliseconds.
    localparam logic [MS_W-1:0] KEY_ON_MS     = 10'h1F4;
    localparam logic [MS_W-1:0] KEY_OFF_MS    = 10'h28A;
    localparam logic [MS_W-1:0] SUPPLY_SET_MS = 10'h01E;

    // Internal startup and power-down durations of the module, in milliseconds.
    localparam logic [MS_W-1:0] BOOT_MS_DFLT = 10'h064;
    localparam logic [MS_W-1:0] HALT_MS_DFLT = 10'h064;

    // Saturation value of the key low interval counter.
    localparam logic [MS_W-1:0] MS_MAX = 10'h3FF;

    typedef enum logic [2:0] {
        DEV_OFF      = 3'h0,
        DEV_BOOT     = 3'h1,
        DEV_RUN      = 3'h2,
        DEV_KEY_HELD = 3'h3,
        DEV_HALT     = 3'h4
    } mpks_dev_state_e;

    typedef enum logic [2:0] {
        HST_OFF       = 3'h0,
        HST_SETTLE    = 3'h1,
        HST_PRESS_ON  = 3'h2,
        HST_ON        = 3'h3,
        HST_PRESS_OFF = 3'h4,
        HST_WAIT_DOWN = 3'h5
    } mpks_host_state_e;

endpackage

// ===== verification/mpks_link_checker.sv
// Concurrent checks on the power key link between the host and the module.
`timescale 1ns/1ps
module mpks_link_checker #(
    parameter int TICK = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic host_key_oe_n,
    input wire logic dev_status_oe_n,
    input wire logic radio_disable_n,
    input wire logic baseband_supply,
    input wire logic radio_supply,
    input wire logic power_key_n,
    input wire logic status_n
);
    int low_ff;
    int sup_ff;
    int nxt_low;
    int nxt_sup;

    // Cycles the key has been low without a break, and cycles the baseband rail has been on.
    always_comb begin
        nxt_low = power_key_n ? 0 : low_ff + 1;
        nxt_sup = baseband_supply ? sup_ff + 1 : 0;
    end

    always_ff @(posedge clk) begin
        low_ff <= reset ? 0 : nxt_low;
        sup_ff <= reset ? 0 : nxt_sup;
    end

    default clocking cb @(posedge clk);
    endclocking

    reset_idle_a: assert property (reset |=> host_key_oe_n && dev_status_oe_n
        && !baseband_supply && !radio_supply && radio_disable_n)
        else $error("link not idle after reset");
    boot_press_a: assert property (disable iff (reset)
        $fell(status_n) |-> low_ff >= 499 * TICK)
        else $error("status low without a long enough key press");
    status_first_a: assert property (disable iff (reset)
        $rose(power_key_n) |-> !status_n)
        else $error("key released before status went low");
    supply_settle_a: assert property (disable iff (reset)
        $fell(power_key_n) |-> sup_ff >= 30 * TICK)
        else $error("key pressed too soon after supply on");
    key_length_a: assert property (disable iff (reset)
        $rose(power_key_n) |-> low_ff >= 500 * TICK)
        else $error("key press too short");
    held_status_a: assert property (disable iff (reset)
        (!status_n && !power_key_n && low_ff >= 650 * TICK) |=> !status_n)
        else $error("power-down finished while key held");
    halt_after_a: assert property (disable iff (reset)
        $rose(power_key_n) |=> !status_n [*8])
        else $error("status released right after key release");
    supply_cut_a: assert property (disable iff (reset)
        ($fell(baseband_supply) || $fell(radio_supply)) |-> status_n)
        else $error("supply removed while module running");
    status_powered_a: assert property (disable iff (reset)
        !status_n |-> baseband_supply && radio_supply)
        else $error("status low without supply");
    unpowered_off_a: assert property (disable iff (reset)
        !baseband_supply ##1 !baseband_supply |-> dev_status_oe_n)
        else $error("status driven without supply");
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the host and module ends joined by their link.
`timescale 1ns/1ps
module testbench
    import mpks_pkg::*;
;
    localparam int              TK = 4;
    localparam logic [MS_W-1:0] BT = 10'h003;
    // Whole run is near 12000 cycles; the limit leaves ample margin.
    localparam int              WD = 50000;

    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        power_on_req = 1'b0;
    logic        power_off_req = 1'b0;
    logic        radio_off = 1'b0;
    logic        shutdown_command = 1'b0;
    logic        functionality_command = 1'b0;
    logic        func_airplane = 1'b0;
    logic        core_power;
    logic        software_active;
    logic        serial_ready;
    logic        radio_enable;
    logic        airplane;
    logic        running;
    logic        module_on;
    logic        strap_pullup_en;
    logic        busy;
    logic [31:0] seed;
    logic [31:0] rv;
    int          num_errors = 0;
    int          tests_run = 0;
    int          n;
    int          bad;
    int          m_air;

    mpks_link_if link();

    mpks_device #(.TICK(TK), .BOOT_MS(BT), .HALT_MS(BT)) mpks_device_i (
        .clk                   (clk),
        .reset                 (reset),
        .link                  (link),
        .shutdown_command      (shutdown_command),
        .functionality_command (functionality_command),
        .func_airplane         (func_airplane),
        .core_power            (core_power),
        .software_active       (software_active),
        .serial_ready          (serial_ready),
        .radio_enable          (radio_enable),
        .airplane              (airplane),
        .running               (running)
    );

    mpks_host #(.TICK(TK)) mpks_host_i (
        .clk             (clk),
        .reset           (reset),
        .link            (link),
        .power_on_req    (power_on_req),
        .power_off_req   (power_off_req),
        .radio_off       (radio_off),
        .module_on       (module_on),
        .strap_pullup_en (strap_pullup_en),
        .busy            (busy)
    );

    mpks_link_checker #(.TICK(TK)) mpks_link_checker_i (
        .clk             (clk),
        .reset           (reset),
        .host_key_oe_n   (link.host_key_oe_n),
        .dev_status_oe_n (link.dev_status_oe_n),
        .radio_disable_n (link.radio_disable_n),
        .baseband_supply (link.baseband_supply),
        .radio_supply    (link.radio_supply),
        .power_key_n     (link.power_key_n),
        .status_n        (link.status_n)
    );

    always #25 clk = ~clk;

    task automatic tick();
        @(posedge clk);
        #2;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic press(input logic off);
        power_on_req = !off;
        power_off_req = off;
        tick();
        power_on_req = 1'b0;
        power_off_req = 1'b0;
        tick();
    endtask

    task automatic pwr_on();
        int t;
        t = 0;
        press(1'b0);
        for (n = 0; n < 9000 && link.power_key_n !== 1'b0; n++) begin
            tick();
        end
        chk("strap early", strap_pullup_en, 0);
        while (t < 9000 && link.status_n !== 1'b0) begin
            t++;
            tick();
        end
        chk("boot time", t >= (498 + BT) * TK && t <= (500 + BT) * TK + 2, 1);
        chk("key held", link.power_key_n, 0);
        for (n = 0; n < 9000 && module_on !== 1'b1; n++) begin
            tick();
        end
        m_air = 0;
        chk("running", running, 1);
        chk("host idle", busy, 0);
        chk("strap on", strap_pullup_en, 1);
        chk("software", software_active, 1);
    endtask

    task automatic wait_off();
        // Busy stays low in the on state while a command shutdown runs, so watch both.
        for (n = 0; n < 9000 && (busy !== 1'b0 || module_on !== 1'b0); n++) begin
            tick();
        end
        chk("core off", core_power, 0);
        chk("host off", module_on, 0);
        chk("supply off", link.baseband_supply, 0);
        chk("radio rail off", link.radio_supply, 0);
    endtask

    initial begin
        seed = 32'h4371;
        repeat (4) @(posedge clk);
        #2;
        reset = 1'b0;
        chk("status idle", link.status_n, 1);
        chk("serial idle", serial_ready, 0);
        $display("test reset done");
        pwr_on();
        chk("radio on", radio_enable, 1);
        $display("test power_on done");
        for (int i = 0; i < 8; i++) begin
            rv = $random(seed);
            func_airplane = rv[0];
            radio_off = rv[1];
            functionality_command = rv[2];
            m_air = rv[2] ? rv[0] : m_air;
            tick();
            functionality_command = 1'b0;
            repeat (2) tick();
            chk("disable pin", link.radio_disable_n, !rv[1]);
            chk("airplane", airplane, m_air | rv[1]);
            chk("radio", radio_enable, !(m_air | rv[1]));
        end
        radio_off = 1'b0;
        $display("test airplane done");
        press(1'b1);
        bad = 0;
        for (n = 0; n < 9000 && link.power_key_n !== 1'b1; n++) begin
            bad += (serial_ready !== 1'b1);
            tick();
        end
        chk("up while held", bad, 0);
        chk("press length", n >= 650 * TK, 1);
        tick();
        chk("halt begun", serial_ready, 0);
        wait_off();
        $display("test key_off done");
        pwr_on();
        shutdown_command = 1'b1;
        tick();
        shutdown_command = 1'b0;
        chk("cmd halt", serial_ready, 0);
        bad = 0;
        for (n = 0; n < 9000 && module_on !== 1'b0; n++) begin
            bad += (link.power_key_n !== 1'b1);
            tick();
        end
        chk("key kept high", bad, 0);
        wait_off();
        $display("test cmd_off done");
        pwr_on();
        press(1'b1);
        repeat (550 * TK) tick();
        shutdown_command = 1'b1;
        tick();
        shutdown_command = 1'b0;
        for (n = 0; n < 300 && running !== 1'b1; n++) begin
            tick();
        end
        chk("restart", running, 1);
        chk("key still low", link.power_key_n, 0);
        for (n = 0; n < 9000 && link.power_key_n !== 1'b1; n++) begin
            tick();
        end
        tick();
        shutdown_command = 1'b1;
        tick();
        shutdown_command = 1'b0;
        wait_off();
        shutdown_command = 1'b1;
        tick();
        shutdown_command = 1'b0;
        tick();
        chk("off ignores cmd", core_power, 0);
        $display("test restart done");
        give_verdict();
    end

    initial begin
        #(WD * 50);
        num_errors++;
        give_verdict();
    end
endmodule
